// >>> verilog/lssel_pkg.sv
// Package with register map, field positions and reset values of the sync input select block.
package lssel_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [3:0] LSSEL_CTRL_ADDR = 4'h0;
	localparam logic [3:0] LSSEL_STAT_ADDR = 4'h4;
	// ****************************************
	// Control field positions
	// ****************************************
	localparam int LSSEL_SYNC_SEL_BIT = 0;
	localparam int LSSEL_MARK_EN_BIT = 1;
	localparam int LSSEL_RECV_EN_BIT = 2;
	localparam int LSSEL_MODE_BIT = 3;
	localparam int LSSEL_REF_DC_BIT = 4;
	localparam int LSSEL_MARK_DC_BIT = 5;
	localparam int LSSEL_CTRL_W = 6;
	localparam logic [5:0] LSSEL_CTRL_RST = 6'h00;
	// ****************************************
	// Status field positions
	// ****************************************
	localparam int LSSEL_ST_SYNC_BIT = 0;
	localparam int LSSEL_ST_CGS_BIT = 1;
	localparam int LSSEL_ST_ILAS_BIT = 2;
	localparam int LSSEL_ST_DATA_BIT = 3;
	localparam int LSSEL_ST_REFSEEN_BIT = 4;
	localparam logic [31:0] LSSEL_RD_ZERO = 32'h00000000;
	// Link initialization states.
	typedef enum logic [1:0] {LSSEL_IDLE, LSSEL_CGS, LSSEL_ILAS, LSSEL_DATA} lssel_state_t;
endpackage

// >>> verilog/lssel_top.sv
// Sync source select, link initialization control and Wishbone registers.
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module lssel_top (
	// Clock and reset.
	input wire logic I_CLOCK,
	input wire logic I_SYS_RST,
	// Wishbone slave.
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [3:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	// Link pins.
	input wire logic I_SYNC_SINGLE_ENDED_N,
	input wire logic I_DIFF_MARK_PAIR,
	input wire logic I_SYSREF,
	input wire logic I_CGS_DONE,
	// Link control outputs.
	output logic O_CGS_START,
	output logic O_ILAS_START,
	output logic O_SAMPLE_MARK,
	output logic O_SYNC_TRIGGER,
	output logic O_REF_EVENT,
	output logic O_REF_DC_COUPLING,
	output logic O_MARK_DC_COUPLING
);
	// ****************************************
	// Registers
	// ****************************************
	logic [5:0] ctrl, next_ctrl;
	logic [31:0] rdat, next_rdat;
	logic ack, next_ack;
	logic sync_q, next_sync_q;
	logic sref_q, next_sref_q;
	logic ref_seen, next_ref_seen;
	logic cgs_p, next_cgs_p, ilas_p, next_ilas_p;
	logic mark, next_mark, trig, next_trig, refev, next_refev;
	lssel_pkg::lssel_state_t st, next_st;
	logic pair_n, sync_n, mode_64, req;
	logic sel_pair, mark_en, rx_en;

	// Control bits by name, so the paths below read as the rules do.
	assign sel_pair = ctrl[lssel_pkg::LSSEL_SYNC_SEL_BIT];
	assign mark_en = ctrl[lssel_pkg::LSSEL_MARK_EN_BIT];
	assign rx_en = ctrl[lssel_pkg::LSSEL_RECV_EN_BIT];
	// Pair gated by receiver enable; disabled pair reads deasserted high.
	// Forcing high rather than passing the unused pin keeps a disabled
	// receiver from ever starting a link reset or marking a sample.
	assign pair_n = rx_en ? I_DIFF_MARK_PAIR : 1'b1;
	// Source select; low level is the asserted request for either source.
	assign sync_n = sel_pair ? pair_n : I_SYNC_SINGLE_ENDED_N;
	assign mode_64 = ctrl[lssel_pkg::LSSEL_MODE_BIT];
	assign req = I_WB_CYC & I_WB_STB & ~ack;

	// ****************************************
	// Bus decode
	// ****************************************
	// A read of one register; used by the sticky clear and the checks.
	function automatic logic rd_hit(input logic r, input logic w,
		input logic [3:0] a, input logic [3:0] want);
		return r && !w && a == want;
	endfunction
	// A write of one register; a write elsewhere leaves control alone.
	function automatic logic wr_hit(input logic r, input logic w,
		input logic [3:0] a, input logic [3:0] want);
		return r && w && a == want;
	endfunction

	// Bus access, link state and output pulses. Answers one cycle after request.
	always_comb begin
		next_ctrl = ctrl;
		next_ack = req;
		next_rdat = rdat;
		if (wr_hit(req, I_WB_WE, I_WB_ADR, lssel_pkg::LSSEL_CTRL_ADDR)
			&& I_WB_SEL[0]) begin
			next_ctrl = I_WB_DAT[5:0];
		end
		if (req && !I_WB_WE) begin
			next_rdat = lssel_pkg::LSSEL_RD_ZERO;
			if (I_WB_ADR == lssel_pkg::LSSEL_CTRL_ADDR) begin
				next_rdat[5:0] = ctrl;
			end else if (I_WB_ADR == lssel_pkg::LSSEL_STAT_ADDR) begin
				next_rdat[lssel_pkg::LSSEL_ST_SYNC_BIT] = sync_q;
				next_rdat[lssel_pkg::LSSEL_ST_CGS_BIT] = (st == lssel_pkg::LSSEL_CGS);
				next_rdat[lssel_pkg::LSSEL_ST_ILAS_BIT] = (st == lssel_pkg::LSSEL_ILAS);
				next_rdat[lssel_pkg::LSSEL_ST_DATA_BIT] = (st == lssel_pkg::LSSEL_DATA);
				next_rdat[lssel_pkg::LSSEL_ST_REFSEEN_BIT] = ref_seen;
			end
		end
		next_sync_q = sync_n;
		next_sref_q = I_SYSREF;
		// A read of status clears ref_seen, but a new edge wins.
		next_ref_seen = ref_seen;
		if (rd_hit(req, I_WB_WE, I_WB_ADR, lssel_pkg::LSSEL_STAT_ADDR)) begin
			next_ref_seen = 1'b0;
		end
		next_refev = I_SYSREF & ~sref_q;
		if (next_refev) begin
			next_ref_seen = 1'b1;
		end
		next_mark = ctrl[lssel_pkg::LSSEL_MARK_EN_BIT] & ~pair_n;
		next_trig = sync_q & ~sync_n;
		next_cgs_p = 1'b0;
		next_ilas_p = 1'b0;
		next_st = st;
		case (st)
			lssel_pkg::LSSEL_IDLE: begin
				if (!mode_64 && !sync_n) begin
					next_st = lssel_pkg::LSSEL_CGS;
					next_cgs_p = 1'b1;
				end
			end
			lssel_pkg::LSSEL_CGS: begin
				if (sync_n && I_CGS_DONE) begin
					next_st = lssel_pkg::LSSEL_ILAS;
					next_ilas_p = 1'b1;
				end
			end
			lssel_pkg::LSSEL_ILAS: begin
				next_st = lssel_pkg::LSSEL_DATA;
			end
			lssel_pkg::LSSEL_DATA: begin
				if (!sync_n) begin
					next_st = lssel_pkg::LSSEL_CGS;
					next_cgs_p = 1'b1;
				end
			end
			default: next_st = lssel_pkg::LSSEL_IDLE;
		endcase
		if (mode_64) begin
			next_st = lssel_pkg::LSSEL_IDLE;
			next_cgs_p = 1'b0;
			next_ilas_p = 1'b0;
		end
	end

	// Register stage.
	// Every output is taken from a flip-flop, so the receiver logic and
	// the bus never see a glitch from the select or the state decode.
	always_ff @(posedge I_CLOCK) begin
		if (I_SYS_RST) begin
			ctrl <= lssel_pkg::LSSEL_CTRL_RST;
			rdat <= lssel_pkg::LSSEL_RD_ZERO;
			ack <= 1'b0;
			sync_q <= 1'b1;
			sref_q <= 1'b0;
			ref_seen <= 1'b0;
			cgs_p <= 1'b0;
			ilas_p <= 1'b0;
			mark <= 1'b0;
			trig <= 1'b0;
			refev <= 1'b0;
			st <= lssel_pkg::LSSEL_IDLE;
		end else begin
			ctrl <= next_ctrl;
			rdat <= next_rdat;
			ack <= next_ack;
			sync_q <= next_sync_q;
			sref_q <= next_sref_q;
			ref_seen <= next_ref_seen;
			cgs_p <= next_cgs_p;
			ilas_p <= next_ilas_p;
			mark <= next_mark;
			trig <= next_trig;
			refev <= next_refev;
			st <= next_st;
		end
	end

	assign O_WB_ACK = ack;
	assign O_WB_DAT = rdat;
	assign O_CGS_START = cgs_p;
	assign O_ILAS_START = ilas_p;
	assign O_SAMPLE_MARK = mark;
	assign O_SYNC_TRIGGER = trig;
	assign O_REF_EVENT = refev;
	assign O_REF_DC_COUPLING = ctrl[lssel_pkg::LSSEL_REF_DC_BIT];
	assign O_MARK_DC_COUPLING = ctrl[lssel_pkg::LSSEL_MARK_DC_BIT];

	// ****************************************
	// Assertions
	// ****************************************
	sel_single_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		!ctrl[0] |-> ##1 (sync_q == $past(I_SYNC_SINGLE_ENDED_N)))
		else $error("single-ended sync not selected");
	sel_pair_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(ctrl[0] && ctrl[2]) |-> ##1 (sync_q == $past(I_DIFF_MARK_PAIR)))
		else $error("pair sync not selected");
	no_init_64_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		mode_64 |-> ##1 (!cgs_p && !ilas_p))
		else $error("link init in 64b mode");
	cgs_start_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(st == lssel_pkg::LSSEL_IDLE && !mode_64 && !sync_n) |=> cgs_p)
		else $error("cgs not started");
	ilas_high_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		ilas_p |-> $past(sync_n))
		else $error("ilas without sync high");
	low_active_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(ctrl[0] && ctrl[2] && !I_DIFF_MARK_PAIR) |-> !sync_n)
		else $error("pair low not asserted");
	mark_pair_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(ctrl[1] && ctrl[2] && !I_DIFF_MARK_PAIR) |=> mark)
		else $error("mark missing");
	rx_off_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		!ctrl[2] |=> !mark)
		else $error("mark with receiver off");
	ref_edge_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		$rose(I_SYSREF) |=> refev)
		else $error("ref event missing");
	ref_only_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		refev |-> $past(I_SYSREF))
		else $error("ref event without reference");
	refseen_set_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		refev |-> ref_seen)
		else $error("ref seen flag not set");
	refseen_clr_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(rd_hit(req, I_WB_WE, I_WB_ADR, lssel_pkg::LSSEL_STAT_ADDR)
		&& !(I_SYSREF && !sref_q)) |=> !ref_seen)
		else $error("ref seen flag not cleared");
	// Bus answer and register contents.
	ack_answer_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		req |=> ack)
		else $error("bus request not answered");
	ack_pulse_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		ack |=> !ack)
		else $error("ack longer than one cycle");
	ctrl_write_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(wr_hit(req, I_WB_WE, I_WB_ADR, lssel_pkg::LSSEL_CTRL_ADDR)
		&& I_WB_SEL[0]) |=> ctrl == $past(I_WB_DAT[5:0]))
		else $error("control write lost");
	ctrl_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		!(wr_hit(req, I_WB_WE, I_WB_ADR, lssel_pkg::LSSEL_CTRL_ADDR)
		&& I_WB_SEL[0]) |=> ctrl == $past(ctrl))
		else $error("control changed without write");
	rd_ctrl_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		rd_hit(req, I_WB_WE, I_WB_ADR, lssel_pkg::LSSEL_CTRL_ADDR)
		|=> rdat == {26'h0, $past(ctrl)})
		else $error("control read wrong");
	rd_stat_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		rd_hit(req, I_WB_WE, I_WB_ADR, lssel_pkg::LSSEL_STAT_ADDR)
		|=> (rdat[0] == $past(sync_q) && rdat[31:5] == 27'h0))
		else $error("status read wrong");
	rd_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		!(req && !I_WB_WE) |=> rdat == $past(rdat))
		else $error("read data changed without read");
	// Link initialization sequence.
	cgs_in_state_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		cgs_p |-> st == lssel_pkg::LSSEL_CGS)
		else $error("cgs pulse outside cgs");
	cgs_again_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(st == lssel_pkg::LSSEL_DATA && !mode_64 && !sync_n) |=> cgs_p)
		else $error("cgs not restarted");
	cgs_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(st == lssel_pkg::LSSEL_CGS && !mode_64 && !(sync_n && I_CGS_DONE))
		|=> st == lssel_pkg::LSSEL_CGS)
		else $error("cgs left while sync low");
	ilas_in_state_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		ilas_p |-> st == lssel_pkg::LSSEL_ILAS)
		else $error("ilas pulse outside ilas");
	ilas_after_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		ilas_p |-> $past(st) == lssel_pkg::LSSEL_CGS)
		else $error("ilas without cgs");
	ilas_one_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		ilas_p |=> !ilas_p)
		else $error("ilas pulse too long");
	ilas_data_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(st == lssel_pkg::LSSEL_ILAS && !mode_64)
		|=> st == lssel_pkg::LSSEL_DATA)
		else $error("data state not entered");
	pulse_excl_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		!(cgs_p && ilas_p))
		else $error("cgs and ilas together");
	idle_64_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		mode_64 |=> st == lssel_pkg::LSSEL_IDLE)
		else $error("link state in 64b mode");
	// Sync path and trigger.
	trig_fall_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(sync_q && !sync_n) |=> trig)
		else $error("trigger missing");
	trig_only_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		trig |-> ($past(sync_q) && !$past(sync_n)))
		else $error("trigger without falling sync");
	single_path_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		!sel_pair |-> sync_n == I_SYNC_SINGLE_ENDED_N)
		else $error("single-ended path wrong");
	pair_off_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(sel_pair && !rx_en) |-> sync_n)
		else $error("sync from disabled pair");
	// Sample mark.
	mark_off_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		!mark_en |=> !mark)
		else $error("mark while disabled");
	mark_only_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		mark |-> $past(rx_en && mark_en && !I_DIFF_MARK_PAIR))
		else $error("mark without low pair");
	both_roles_a: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
		(sel_pair && rx_en && mark_en && !I_DIFF_MARK_PAIR)
		|=> (mark && !sync_q))
		else $error("pair not serving both roles");
endmodule
`default_nettype wire

// >>> verif/lssel_rx_model.sv
// Receiver-side model that requests link sync and reports code group sync.
`timescale 1ns/1ns
`default_nettype none
module lssel_rx_model (
	// Clock, reset and request.
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_go,
	// Link side.
	output logic o_sync_n,
	output logic o_cgs_done
);
	int cnt;
	// Sync stays low for a random stretch, so the device cannot lean on
	// a fixed length; it is released together with the done level.
	always @(posedge i_clk) begin
		if (i_rst) begin
			cnt <= 0;
			o_sync_n <= 1'b1;
			o_cgs_done <= 1'b0;
		end else if (i_go) begin
			cnt <= 3 + $urandom_range(5);
			o_sync_n <= 1'b0;
			o_cgs_done <= 1'b0;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			o_sync_n <= (cnt == 1);
			o_cgs_done <= (cnt == 1);
		end
	end
endmodule
`default_nettype wire

// >>> verif/tb_lssel_top.sv
// Self-checking bench of the sync input select block.
`timescale 1ns/1ns
`default_nettype none
module tb_lssel_top;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, cgs, ilas, mk;
	logic trg, ev, rdc, mdc, se, pr, sr = 0, go = 0, rs, cd, nz = 1, nzen = 0;
	logic [3:0] adr = 0;
	logic [5:0] cf = 0, v;
	logic [31:0] wd = 0, rd, q;
	int fails = 0, n_tests = 0, c[5], e[5], em = 0, i, dat = 0, ok;
	lssel_top dut (.I_CLOCK(clk), .I_SYS_RST(rst), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf),
		.I_WB_DAT(wd), .O_WB_DAT(rd), .O_WB_ACK(ack),
		.I_SYNC_SINGLE_ENDED_N(se), .I_DIFF_MARK_PAIR(pr), .I_SYSREF(sr),
		.I_CGS_DONE(cd), .O_CGS_START(cgs), .O_ILAS_START(ilas),
		.O_SAMPLE_MARK(mk), .O_SYNC_TRIGGER(trg), .O_REF_EVENT(ev),
		.O_REF_DC_COUPLING(rdc), .O_MARK_DC_COUPLING(mdc));
	lssel_rx_model rx (.i_clk(clk), .i_rst(rst), .i_go(go), .o_sync_n(rs),
		.o_cgs_done(cd));
	// The unused single-ended pin is tied low, as a board would do.
	assign se = cf[0] ? 1'b0 : rs;
	assign pr = cf[0] ? rs : nz;
	initial begin
		forever #10 clk = ~clk;
	end
	// Counts pulses seen, and predicts marks from the pair level per cycle.
	always @(posedge clk) begin
		nz <= nzen ? 1'($urandom) : 1'b1;
		if (!rst) begin
			c[0] += cgs;
			c[1] += ilas;
			c[2] += trg;
			c[3] += mk;
			c[4] += ev;
			em += cf[1] & cf[2] & !pr;
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x) begin
			fails++;
			$display("CHECK FAILED %0t %h %h", $time, s, x);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One classic cycle; the reply is taken at the edge that sees ack.
	task automatic wb(input logic w1, input logic [3:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w1;
		adr <= a;
		wd <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rd;
		cyc <= 0;
		stb <= 0;
		if (ack !== 1'b1) begin
			fails++;
			give_verdict();
		end
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(76));
		repeat (12) @(posedge clk);
		rst <= 0;
		wb(1, 4'h4, 32'hffffffff);
		wb(0, 4'h0, 0);
		chk(q, {26'h0, lssel_pkg::LSSEL_CTRL_RST});
		wb(0, 4'h8, 0);
		chk(q, 0);
		// Every mix of select, mark, receiver and mode, random coupling.
		for (i = 0; i < 16; i++) begin
			v = {2'($urandom), 4'(i)};
			// Lift the tied-low pin before the device selects it.
			if (!v[0])
				cf <= v;
			wb(1, 4'h0, {26'h0, v});
			cf <= v;
			wb(0, 4'h0, 0);
			chk(q, {26'h0, v});
			chk({rdc, mdc}, {v[4], v[5]});
			ok = !v[0] || v[2];
			nzen <= 1;
			go <= 1;
			sr <= 1;
			@(posedge clk);
			go <= 0;
			sr <= 0;
			repeat (20) @(posedge clk);
			nzen <= 0;
			repeat (4) @(posedge clk);
			e[0] += ok && !v[3];
			e[1] += ok && !v[3];
			e[2] += ok;
			e[4] += 1;
			dat = v[3] ? 0 : (ok ? 1 : dat);
			chk(c[0], e[0]);
			chk(c[1], e[1]);
			chk(c[2], e[2]);
			chk(c[3], em);
			chk(c[4], e[4]);
			wb(0, 4'h4, 0);
			chk(q, {27'h0, 1'b1, 1'(dat), 3'b001});
		end
		give_verdict();
	end
endmodule
`default_nettype wire
